// >>> dv/dsa_front_model.sv
`timescale 1ns/1ps
`default_nettype none
module dsa_front_model (
  input  wire logic             i_mclk, // clock
  input  wire dsa_pkg::dsa_sw_s i_sw,   // switches
  input  var  int               i_vin,  // input, in counts
  output logic                  o_comp  // integrator above zero
);
  int acc = 0; // integrated charge, positive input builds up
  // null loops empty it, input or reference moves it
  always @(posedge i_mclk)
    if (i_sw.az_loop || i_sw.zi_loop)
      acc <= 0;
    else if (i_sw.input_connect)
      acc <= acc + i_vin;
    else if (i_sw.ref_pos)
      acc <= acc + 1000;
    else if (i_sw.ref_neg)
      acc <= acc - 1000;
  // output goes down for positive input
  assign o_comp = acc < 0;
endmodule
`default_nettype wire

// >>> dv/dsa_monitor.sv
`timescale 1ns/1ps
`default_nettype none
module dsa_monitor (
  input wire logic                i_mclk,      // clock
  input wire logic                i_rst,       // reset
  input wire logic                i_comp,      // comparator
  input wire dsa_pkg::dsa_sw_s    o_sw,        // switches
  input wire dsa_pkg::dsa_phase_e o_phase,     // phase
  input wire dsa_pkg::dsa_read_s  o_reading,   // reading
  input wire logic                o_read_valid // update pulse
);
  import dsa_pkg::*;
  dsa_phase_e  prev_r; // phase one edge ago
  logic [15:0] cnt_r;  // cycles spent in phase
  wire logic   chg = o_phase != prev_r; // phase just changed
  // phase age counter
  always_ff @(posedge i_mclk or posedge i_rst)
    if (i_rst)
    begin
      prev_r <= DSA_AZ;
      cnt_r  <= 16'h0000;
    end
    else
    begin
      prev_r <= o_phase;
      cnt_r  <= chg ? 16'h0001 : cnt_r + 16'h0001;
    end
  default clocking @(posedge i_mclk); endclocking
  default disable iff (i_rst);
  az_switches_a: assert property (o_phase == DSA_AZ |-> o_sw == 7'h58)
    else $error("az switches");
  int_switches_a: assert property (o_phase == DSA_INT |-> o_sw.input_connect &&
    !o_sw.az_loop && !o_sw.hi_short_lo && !o_sw.ref_pos && !o_sw.ref_neg) else $error("int sw");
  de_reference_a: assert property (o_phase == DSA_DE |->
    o_sw.ref_pos != o_sw.ref_neg && !o_sw.input_connect) else $error("de reference");
  zi_switches_a: assert property (o_phase == DSA_ZI |-> o_sw.zi_loop &&
    o_sw.ref_charge && !o_sw.ref_pos && !o_sw.ref_neg) else $error("zi switches");
  phase_order_a: assert property (!$stable(o_phase) |->
    o_phase == dsa_phase_e'($past(o_phase) + 2'h1)) else $error("phase order");
  int_length_a: assert property (chg && prev_r == DSA_INT |-> cnt_r == 16'h0fa0)
    else $error("int length");
  zi_length_a: assert property (chg && prev_r == DSA_ZI |->
    cnt_r == (o_reading.overrange ? 16'h0e10 : 16'h0028)) else $error("zi length");
  az_short_a: assert property (chg && prev_r == DSA_AZ && o_reading.overrange |->
    cnt_r == 16'h0190) else $error("az length");
  reading_hold_a: assert property ($changed(o_reading) |-> o_read_valid)
    else $error("reading moved");
  over_reading_a: assert property (o_read_valid && o_reading.overrange |->
    o_reading.bcd == 16'h1999) else $error("over reading");
  sign_kept_a: assert property (o_read_valid |->
    o_reading.negative == $past(o_sw.ref_pos)) else $error("sign kept");
  de_stop_a: assert property (o_phase == DSA_DE && $changed(i_comp) |->
    ##[1:6] o_phase != DSA_DE) else $error("de stop");
  cover property (o_read_valid && o_reading.negative);
  cover property (o_read_valid && o_reading.overrange);
  cover property (chg && prev_r == DSA_DE);
endmodule
bind dsa_sequencer dsa_monitor u_dsa_monitor (.i_mclk(i_mclk), .i_rst(i_rst), .i_comp(i_comp),
  .o_sw(o_sw), .o_phase(o_phase), .o_reading(o_reading), .o_read_valid(o_read_valid));
`default_nettype wire

// >>> dv/testbench.sv
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import dsa_pkg::*;
  logic       i_mclk = 1'b0; // clock
  logic       i_rst  = 1'b1; // reset
  logic       comp;          // comparator
  dsa_sw_s    sw;            // switches
  dsa_phase_e ph;            // phase
  dsa_read_s  rd;            // reading
  dsa_read_s  rdq;           // last pulsed reading
  logic       vld;           // update pulse
  int         vin = 250;     // input voltage in counts
  int         n_errors = 0;
  int         cmp_count = 0;
  int         cyc = 0;
  int         len [4];       // cycles per phase
  dsa_sequencer u_dsa_sequencer (.i_mclk(i_mclk), .i_rst(i_rst), .i_comp(comp), .o_sw(sw),
    .o_phase(ph), .o_reading(rd), .o_read_valid(vld));
  dsa_front_model u_dsa_front_model (.i_mclk(i_mclk), .i_sw(sw), .i_vin(vin), .o_comp(comp));
  initial forever #2.5 i_mclk = ~i_mclk;
  // capture reading, cut a hang short
  always @(posedge i_mclk)
  begin
    cyc++;
    if (vld === 1'b1)
      rdq <= rd;
    if (cyc == 100000)
    begin
      n_errors++;
      give_verdict();
    end
  end
  task automatic give_verdict();
    if (n_errors == 0 && cmp_count > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp)
    begin
      n_errors++;
      $display("wrong value at %0t: %h not %h", $time, seen, exp);
    end
  endtask
  function automatic logic signed [31:0] b2i(input logic [15:0] b);
    return b[15:12] * 1000 + b[11:8] * 100 + b[7:4] * 10 + b[3:0];
  endfunction
  // time int, de, zi and az in turn
  task automatic walk();
    for (int p = 1; p < 5; p++)
    begin
      len[p % 4] = 0;
      while (ph === dsa_phase_e'(p % 4))
      begin
        @(posedge i_mclk);
        #1;
        len[p % 4]++;
      end
    end
  endtask
  // one in-range conversion
  task automatic normal(input int v, input int e, input logic neg);
    vin = v;
    walk();
    check(len[1], 4000);
    check(b2i(rdq.bcd) >= e - 1 && b2i(rdq.bcd) <= e + 1, 1);
    check({rdq.negative, rdq.overrange}, {neg, 1'b0});
    check(len[3], 40);
    check(len[0] + len[1] + len[2] + len[3], 16000);
    check(len[2], 4 * (b2i(rdq.bcd) + 1));
    check(len[0], 4 * (2989 - b2i(rdq.bcd)));
  endtask
  task automatic t_positive();
    normal(250, 250, 1'b0);
  endtask
  task automatic t_negative();
    normal(-1234, 1234, 1'b1);
  endtask
  task automatic t_zero();
    normal(0, 0, 1'b0);
  endtask
  task automatic t_overrange();
    vin = 2500;
    walk();
    check(rdq.overrange, 1);
    check(rdq.bcd, 16'h1999);
    check(len[2], 8000);
    check(len[3], 3600);
    check(len[0], 400);
    check(ph, DSA_INT);
  endtask
  task automatic t_recover();
    normal(1500, 1500, 1'b0);
  endtask
  initial
  begin
    repeat (2) @(posedge i_mclk);
    #1 i_rst = 1'b0;
    while (ph !== DSA_INT)
    begin
      @(posedge i_mclk);
      #1;
    end
    t_positive();
    t_negative();
    t_zero();
    t_overrange();
    t_recover();
    give_verdict();
  end
endmodule
`default_nettype wire

// >>> hw/dsa_bcd_counter.sv
`timescale 1ns/1ps
`default_nettype none
module dsa_bcd_counter (
  input  wire logic        i_mclk,  // system clock
  input  wire logic        i_rst,   // async reset, high
  input  wire logic        i_clear, // synchronous clear
  input  wire logic        i_inc,   // count one step
  output logic      [15:0] o_bcd    // bcd digits
);
  import dsa_pkg::*;

  logic [3:0] carry; // carry into each digit

  assign carry[0] = i_inc;

  // digit chain
  genvar g;
  generate
    for (g = 0; g < 4; g++)
    begin : g_dig
      if (g < 3)
      begin : g_c
        assign carry[g+1] = carry[g] & (o_bcd[4*g +: 4] == 4'h9);
      end
      always_ff @(posedge i_mclk or posedge i_rst)
      begin
        if (i_rst)
          o_bcd[4*g +: 4] <= 4'h0;
        else if (i_clear)
          o_bcd[4*g +: 4] <= 4'h0;
        // digit wraps after nine
        else if (carry[g])
          o_bcd[4*g +: 4] <= (o_bcd[4*g +: 4] == 4'h9) ? 4'h0 : o_bcd[4*g +: 4] + 4'h1;
      end
    end
  endgenerate
endmodule
`default_nettype wire

// >>> hw/dsa_pkg.sv
package dsa_pkg;
  // clock divider and phase lengths, in counts
  localparam int unsigned CLK_DIV        = 4;      // oscillator to count rate
  localparam logic [1:0]  DIV_LAST       = 2'h3;   // last divider state
  localparam logic [11:0] INT_COUNTS     = 12'h3e8; // 1000 counts
  localparam logic [11:0] DEINT_MAX      = 12'h7d0; // 2000 counts
  localparam logic [11:0] CYCLE_COUNTS   = 12'hfa0; // 4000 counts
  localparam logic [11:0] AZ_MIN         = 12'h3de; // 990 counts
  localparam logic [11:0] AZ_OVER        = 12'h064; // 100 counts
  localparam logic [11:0] ZI_NORMAL      = 12'h00a; // 10 counts
  localparam logic [11:0] ZI_OVER        = 12'h384; // 900 counts
  localparam logic [11:0] MAX_READING    = 12'h7cf; // 1999
  localparam logic [15:0] BCD_RESET      = 16'h0000; // counter after reset

  // conversion phases
  typedef enum logic [1:0] {
    DSA_AZ  = 2'b00,
    DSA_INT = 2'b01,
    DSA_DE  = 2'b10,
    DSA_ZI  = 2'b11
  } dsa_phase_e;

  // analog switch controls
  typedef struct packed {
    logic hi_short_lo;   // input high shorted to input low
    logic input_connect; // external inputs routed to integrator
    logic ref_charge;    // reference capacitor across reference
    logic az_loop;       // offset null loop closed
    logic ref_pos;       // reference connected positive
    logic ref_neg;       // reference connected negative
    logic zi_loop;       // comparator fed back to internal high
  } dsa_sw_s;

  // latched reading
  typedef struct packed {
    logic        negative;  // sign of input
    logic        overrange; // deintegration hit limit
    logic [15:0] bcd;       // four bcd digits, top is 0 or 1
  } dsa_read_s;
endpackage

// >>> hw/dsa_sequencer.sv
`timescale 1ns/1ps
`default_nettype none
module dsa_sequencer (
  input  wire logic               i_mclk,      // oscillator clock
  input  wire logic               i_rst,       // async reset, high
  input  wire logic               i_comp,      // comparator, high: integrator above zero
  output dsa_pkg::dsa_sw_s        o_sw,        // analog switch controls
  output dsa_pkg::dsa_phase_e     o_phase,     // current phase
  output dsa_pkg::dsa_read_s      o_reading,   // latched reading
  output logic                    o_read_valid // pulse when reading updated
);
  import dsa_pkg::*;

  dsa_phase_e  phase_r;      // phase register
  logic [1:0]  div_r;        // divide by four
  logic        tick;         // count enable
  logic [11:0] len_r;        // binary count in phase
  logic [11:0] de_len_r;     // counts used by deintegrate
  logic        neg_r;        // sampled sign
  logic        over_r;       // overrange of last conversion
  logic        comp_s1_r;    // synchroniser first stage
  logic        comp_s2_r;    // synchronised comparator
  logic        comp_start_r; // comparator level at deintegrate start
  logic [15:0] bcd;          // bcd counter value
  logic        bcd_clr;      // counter clear
  logic        bcd_inc;      // counter step
  logic        crossed;      // zero crossing seen
  logic        de_end;       // deintegrate ends this tick
  logic        az_end;       // auto-zero ends this tick
  logic        zi_end;       // zero integrate ends this tick
  logic [11:0] az_len;       // auto-zero length this cycle

  // comparator comes from the analog side
  always_ff @(posedge i_mclk or posedge i_rst)
  begin
    if (i_rst)
    begin
      comp_s1_r <= 1'b0;
      comp_s2_r <= 1'b0;
    end
    else
    begin
      comp_s1_r <= i_comp;
      comp_s2_r <= comp_s1_r;
    end
  end

  always_ff @(posedge i_mclk or posedge i_rst)
  begin
    if (i_rst)
      div_r <= 2'h0;
    else
      div_r <= div_r + 2'h1;
  end
  assign tick = (div_r == DIV_LAST);

  assign crossed = (comp_s2_r != comp_start_r);
  assign de_end  = crossed || (len_r == DEINT_MAX - 12'h1);
  assign az_len  = over_r ? AZ_OVER : (AZ_MIN + (DEINT_MAX - de_len_r));
  assign az_end  = (len_r == az_len - 12'h1);
  assign zi_end  = (len_r == (over_r ? ZI_OVER : ZI_NORMAL) - 12'h1);

  always_ff @(posedge i_mclk or posedge i_rst)
  begin
    if (i_rst)
      phase_r <= DSA_AZ;
    else if (tick)
    begin
      case (phase_r)
        DSA_AZ:  if (az_end) phase_r <= DSA_INT;
        DSA_INT: if (len_r == INT_COUNTS - 12'h1) phase_r <= DSA_DE;
        DSA_DE:  if (de_end) phase_r <= DSA_ZI;
        DSA_ZI:  if (zi_end) phase_r <= DSA_AZ;
        default: phase_r <= DSA_AZ;
      endcase
    end
  end

  // phase length counter, restarts on each phase change
  always_ff @(posedge i_mclk or posedge i_rst)
  begin
    if (i_rst)
      len_r <= 12'h000;
    else if (tick)
    begin
      if ((phase_r == DSA_AZ && az_end) || (phase_r == DSA_INT && len_r == INT_COUNTS - 12'h1)
          || (phase_r == DSA_DE && de_end) || (phase_r == DSA_ZI && zi_end))
        len_r <= 12'h000;
      else
        len_r <= len_r + 12'h1;
    end
  end

  // clear at end of auto-zero; clear at 1000
  assign bcd_clr = tick && ((phase_r == DSA_AZ && az_end)
                   || (phase_r == DSA_INT && len_r == INT_COUNTS - 12'h1));
  assign bcd_inc = tick && !bcd_clr && (phase_r == DSA_INT || (phase_r == DSA_DE && !crossed));

  dsa_bcd_counter u_bcd (
    .i_mclk  (i_mclk),
    .i_rst   (i_rst),
    .i_clear (bcd_clr),
    .i_inc   (bcd_inc),
    .o_bcd   (bcd)
  );

  // sign sampled at end of integrate
  always_ff @(posedge i_mclk or posedge i_rst)
  begin
    if (i_rst)
    begin
      neg_r        <= 1'b0;
      comp_start_r <= 1'b0;
    end
    else if (tick && phase_r == DSA_INT && len_r == INT_COUNTS - 12'h1)
    begin
      // integrator rises for negative input
      neg_r        <= comp_s2_r;
      comp_start_r <= comp_s2_r;
    end
  end

  // deintegrate length and overrange record
  always_ff @(posedge i_mclk or posedge i_rst)
  begin
    if (i_rst)
    begin
      de_len_r <= DEINT_MAX;
      over_r   <= 1'b0;
    end
    else if (tick && phase_r == DSA_DE && de_end)
    begin
      // crossing tick belongs to the phase, so it is counted too
      de_len_r <= crossed ? len_r + 12'h1 : DEINT_MAX;
      over_r   <= !crossed;
    end
  end

  // latch reading at end of measurement
  always_ff @(posedge i_mclk or posedge i_rst)
  begin
    if (i_rst)
    begin
      o_reading    <= '0;
      o_read_valid <= 1'b0;
    end
    else
    begin
      o_read_valid <= 1'b0;
      if (tick && phase_r == DSA_DE && de_end)
      begin
        // count is the ratio reading, capped at 1999
        o_reading.bcd       <= crossed ? bcd : 16'h1999;
        o_reading.negative  <= neg_r;
        o_reading.overrange <= !crossed;
        o_read_valid        <= 1'b1;
      end
    end
  end

  // switch network per phase
  always_comb
  begin
    o_sw = '0;
    case (phase_r)
      // short input, charge ref, close loop
      DSA_AZ:
      begin
        o_sw.hi_short_lo = 1'b1;
        o_sw.ref_charge  = 1'b1;
        o_sw.az_loop     = 1'b1;
      end
      DSA_INT: o_sw.input_connect = 1'b1;
      DSA_DE:
      begin
        o_sw.ref_pos = neg_r;
        o_sw.ref_neg = !neg_r;
      end
      DSA_ZI:
      begin
        o_sw.zi_loop    = 1'b1;
        o_sw.ref_charge = 1'b1;
      end
      default: o_sw = '0;
    endcase
  end

  assign o_phase = phase_r;
endmodule
`default_nettype wire
